/* include/stepdir_pkg.sv */
// Constants for the step/direction microstep front end
package stepdir_pkg;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_CURRENT = 8'h04;
   localparam logic [7:0] REG_DIRECT  = 8'h08;
   localparam logic [7:0] REG_LOAD    = 8'h0c;
   localparam logic [7:0] REG_STATUS  = 8'h10;
   localparam logic [7:0] REG_COIL    = 8'h14;
   // Control register fields
   localparam int CTRL_DEDGE    = 0;
   localparam int CTRL_DIRECT   = 1;
   localparam int CTRL_CYCCHOP  = 2;
   localparam int CTRL_LOADADPT = 3;
   localparam int CTRL_FASTSTILL = 4;
   localparam int CTRL_STILLLO  = 5;
   localparam int CTRL_RESLO    = 8;
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
   localparam logic [31:0] CURRENT_RESET = 32'h0203_081f;
   localparam logic [31:0] LOAD_RESET    = 32'h0000_2008;
   // Current register fields
   localparam int CUR_RUNLO   = 0;
   localparam int CUR_HOLDLO  = 8;
   localparam int CUR_DELAYLO = 16;
   localparam int CUR_DECAYLO = 24;
   // Direct register fields
   localparam int DIR_AMAGLO = 0;
   localparam int DIR_ANEG   = 8;
   localparam int DIR_BMAGLO = 16;
   localparam int DIR_BNEG   = 24;
   // Load register fields
   localparam int LOAD_MINLO = 0;
   localparam int LOAD_THRLO = 8;
   // Status register fields
   localparam int STAT_STILL = 16;
   localparam int STAT_DIR   = 17;
   localparam int STAT_SPI   = 18;
   // Resolution codes: 0 is 256 microsteps, 8 is fullstep
   localparam logic [3:0] RES_FINE = 4'h0;
   localparam logic [3:0] RES_FULL = 4'h8;
   // Serial frame
   localparam int FRAME_BITS = 40;
   localparam logic [5:0] FRAME_LEN = 6'd40;
   // Timing
   localparam int CLK_MHZ     = 100;
   localparam int TICK_NS     = 1000;
   localparam int TICK_CYCLES = (TICK_NS * CLK_MHZ) / 1000;
   localparam int STILL_US      = 10000;
   localparam int FAST_STILL_US = 1000;
   localparam int DELAY_SHIFT   = 10;
   // Standstill behaviour
   typedef enum logic [1:0]
   {
      STILL_REDUCE = 2'b00,
      STILL_FREE   = 2'b01,
      STILL_BRAKE  = 2'b10
   } still_mode_e;
   // Serial receive states
   typedef enum logic [1:0]
   {
      SER_IDLE  = 2'b00,
      SER_SHIFT = 2'b01,
      SER_DONE  = 2'b10
   } ser_state_e;
endpackage

/* src/sine_table.sv */
// Quarter-wave sine table with linear interpolation
`timescale 1ns/10ps
module sine_table
(
   input  wire logic [9:0] phase,   // Electrical angle, 1024 per period
   output logic      [7:0] mag,     // Magnitude 0..255
   output logic            neg      // Negative half wave
);
   logic [8:0] pos;                 // Position within quarter, 0..256
   logic [7:0] lo;
   logic [7:0] hi;
   logic [11:0] span;

   // Seventeen support points over one quarter wave
   function automatic logic [7:0] point(input logic [4:0] k);
      case (k)
         5'd0:  point = 8'h00;  5'd1:  point = 8'h19;  5'd2:  point = 8'h32;
         5'd3:  point = 8'h4a;  5'd4:  point = 8'h62;  5'd5:  point = 8'h79;
         5'd6:  point = 8'h8e;  5'd7:  point = 8'ha2;  5'd8:  point = 8'hb4;
         5'd9:  point = 8'hc5;  5'd10: point = 8'hd4;  5'd11: point = 8'he1;
         5'd12: point = 8'hec;  5'd13: point = 8'hf4;  5'd14: point = 8'hfa;
         5'd15: point = 8'hfe;
         default: point = 8'hff;
      endcase
   endfunction

   // Mirror odd quarters, interpolate between points
   always_comb
   begin
      pos  = phase[8] ? (9'h100 - {1'b0, phase[7:0]}) : {1'b0, phase[7:0]};
      lo   = point(pos[8:4]);
      hi   = (pos[8:4] >= 5'd16) ? 8'hff : point(pos[8:4] + 5'd1);
      span = 12'((hi - lo) * pos[3:0]);
      mag  = 8'(lo + span[11:4]);
      neg  = phase[9];
   end
endmodule // sine_table

/* src/step_dir_front_end.sv */
// Step/direction microstep front end with serial and bus register access
`timescale 1ns/10ps
module step_dir_front_end
#(
   parameter int STILL_TICKS      = stepdir_pkg::STILL_US,
   parameter int FAST_STILL_TICKS = stepdir_pkg::FAST_STILL_US
)
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        haddrSel,          // hsel
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        stepPin,
   input  wire logic        dirPin,
   input  wire logic        spiModeStrap,
   input  wire logic        select_or_cfg_pin3,
   input  wire logic        sclk_or_cfg_pin2,
   input  wire logic        mosi_or_cfg_pin1,
   input  wire logic        miso_or_cfg_pin0_in,
   output logic             miso_or_cfg_pin0_out,
   output logic             miso_or_cfg_pin0_oe,
   input  wire logic [9:0]  loadMeasure,       // From load measurement, same clock
   output logic      [7:0]  coilAMag,
   output logic             coilANeg,
   output logic      [7:0]  coilBMag,
   output logic             coilBNeg,
   output logic      [4:0]  currentScale,
   output logic             cycleChopEn,
   output logic             bridgeOff,
   output logic             brakeOn
);
   import stepdir_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [31:0] ctrl_reg, current_reg, direct_reg, load_reg;
   logic [1:0]  stepSync, dirSync, modeSync, csSync, sclkSync, mosiSync, cfg0Sync;
   logic        stepPrev, csPrev, sclkPrev;
   logic        strapTaken_reg, spiMode_reg;
   logic [9:0]  msCnt_reg;                  // Step position, 1024 per period
   logic [9:0]  interp_reg;                 // Smoothed position
   logic [15:0] period_reg, lastPeriod_reg, interpTimer_reg;
   logic [6:0]  tickDiv_reg;
   logic        tickEn;
   logic [15:0] stillCnt_reg, delayCnt_reg;
   logic [7:0]  decayCnt_reg;
   logic        stepRise, stepFall, stepEdge, dualEdge, standstill, reduceNow;
   logic [3:0]  resCode;
   logic [9:0]  stepIncr, diff;
   logic [15:0] interval;
   logic [7:0]  sinMag, cosMag;
   logic        sinNeg, cosNeg;
   logic [4:0]  targetScale;
   still_mode_e stillMode;
   logic        wrPend_reg;
   logic [7:0]  wrAddr_reg;
   logic        spiWr;
   logic [7:0]  spiAddr;
   logic [31:0] spiData;
   ser_state_e  serState_reg;
   logic [39:0] rxShift_reg, txShift_reg;
   logic [5:0]  bitCnt_reg;
   logic [31:0] spiRead_reg;
   logic        csFall, csRise, sclkRise, sclkFall;

   // Register readback shared by both access paths
   function automatic logic [31:0] readReg(input logic [7:0] a);
      case (a)
         REG_CTRL:    readReg = ctrl_reg;
         REG_CURRENT: readReg = current_reg;
         REG_DIRECT:  readReg = direct_reg;
         REG_LOAD:    readReg = load_reg;
         REG_STATUS:  readReg = {13'h0, spiMode_reg, dirSync[1], standstill, 6'h0, msCnt_reg};
         REG_COIL:    readReg = {7'h0, coilBNeg, coilBMag, 7'h0, coilANeg, coilAMag};
         default:     readReg = 32'h0;   // Unmapped reads as zero
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: first stage only feeds the second
   always_ff @(posedge clk_sys)
   begin
      stepSync <= {stepSync[0], stepPin};
      dirSync  <= {dirSync[0], dirPin};
      modeSync <= {modeSync[0], spiModeStrap};
      csSync   <= {csSync[0], select_or_cfg_pin3};
      sclkSync <= {sclkSync[0], sclk_or_cfg_pin2};
      mosiSync <= {mosiSync[0], mosi_or_cfg_pin1};
      cfg0Sync <= {cfg0Sync[0], miso_or_cfg_pin0_in};
      stepPrev <= stepSync[1];
      csPrev   <= csSync[1];
      sclkPrev <= sclkSync[1];
   end

   // Strap caught once, after reset is released
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         strapTaken_reg <= 1'b0;
         spiMode_reg    <= 1'b0;
      end
      else if (!strapTaken_reg)
      begin
         strapTaken_reg <= 1'b1;
         spiMode_reg    <= modeSync[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Effective configuration: edge and resolution from pins in standalone, registers otherwise; standstill mode always from the register
   always_comb
   begin
      if (spiMode_reg)
      begin
         dualEdge = ctrl_reg[CTRL_DEDGE];
         resCode  = ctrl_reg[CTRL_RESLO +: 4];
      end
      else
      begin
         // cfg pins 1:0 pick 256, 16, 4 or fullstep
         dualEdge = csSync[1];
         case ({mosiSync[1], cfg0Sync[1]})
            2'b00:   resCode = RES_FINE;
            2'b01:   resCode = 4'h4;
            2'b10:   resCode = 4'h6;
            default: resCode = RES_FULL;
         endcase
      end
      stepIncr  = (resCode > RES_FULL) ? 10'd1 : 10'(10'd1 << resCode);
      stepRise  = stepSync[1] & ~stepPrev;
      stepFall  = ~stepSync[1] & stepPrev;
      stepEdge  = stepRise | (dualEdge & stepFall);
      stillMode = still_mode_e'(ctrl_reg[CTRL_STILLLO +: 2]);
      interval  = (resCode > RES_FULL) ? lastPeriod_reg : (lastPeriod_reg >> resCode);
      diff      = msCnt_reg - interp_reg;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Microstep counter, wraps modulo one electrical period
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         msCnt_reg <= 10'h000;
      else if (stepEdge)
         msCnt_reg <= dirSync[1] ? msCnt_reg - stepIncr : msCnt_reg + stepIncr;
   end

   // Step period measurement for interpolation
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         period_reg     <= 16'h0;
         lastPeriod_reg <= 16'hffff;
      end
      else if (stepEdge)
      begin
         period_reg     <= 16'h0;
         lastPeriod_reg <= period_reg;
      end
      else if (period_reg != 16'hffff)
         period_reg <= period_reg + 16'h1;
   end

   // Interpolator walks one fine step per interval toward the target
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         interp_reg      <= 10'h000;
         interpTimer_reg <= 16'h0;
      end
      else if (stepEdge || standstill)
      begin
         // Lagging behind is cut off by snapping to the last target
         interp_reg      <= msCnt_reg;
         interpTimer_reg <= 16'h0;
      end
      else if (diff != 10'h000)
      begin
         if (interpTimer_reg >= interval)
         begin
            interp_reg      <= diff[9] ? interp_reg - 10'h1 : interp_reg + 10'h1;
            interpTimer_reg <= 16'h0;
         end
         else
            interpTimer_reg <= interpTimer_reg + 16'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sine and cosine of the smoothed position
   sine_table sinLut
   (
      .phase (interp_reg),
      .mag   (sinMag),
      .neg   (sinNeg)
   );

   sine_table cosLut
   (
      .phase (10'(interp_reg + 10'h100)),
      .mag   (cosMag),
      .neg   (cosNeg)
   );

   // Coil targets: direct values or table
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         coilAMag <= 8'h00;
         coilANeg <= 1'b0;
         coilBMag <= 8'h00;
         coilBNeg <= 1'b0;
      end
      else if (spiMode_reg && ctrl_reg[CTRL_DIRECT])
      begin
         coilAMag <= direct_reg[DIR_AMAGLO +: 8];
         coilANeg <= direct_reg[DIR_ANEG];
         coilBMag <= direct_reg[DIR_BMAGLO +: 8];
         coilBNeg <= direct_reg[DIR_BNEG];
      end
      else
      begin
         coilAMag <= sinMag;
         coilANeg <= sinNeg;
         coilBMag <= cosMag;
         coilBNeg <= cosNeg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Microsecond tick divider
   always_ff @(posedge clk_sys)
   begin
      if (rst || tickEn)
         tickDiv_reg <= 7'h0;
      else
         tickDiv_reg <= tickDiv_reg + 7'h1;
   end
   assign tickEn = (tickDiv_reg == 7'(TICK_CYCLES - 1));

   // Standstill detection and hold delay
   always_ff @(posedge clk_sys)
   begin
      if (rst || stepEdge)
      begin
         stillCnt_reg <= 16'h0;
         delayCnt_reg <= 16'h0;
      end
      else if (tickEn)
      begin
         if (!standstill)
            stillCnt_reg <= stillCnt_reg + 16'h1;
         else if (!reduceNow)
            delayCnt_reg <= delayCnt_reg + 16'h1;
      end
   end
   // Fast detection trades false hits for quicker hold current
   assign standstill = stillCnt_reg >= (ctrl_reg[CTRL_FASTSTILL] ? 16'(FAST_STILL_TICKS)
                                                                 : 16'(STILL_TICKS));
   assign reduceNow  = standstill &&
                       (delayCnt_reg >= 16'({current_reg[CUR_DELAYLO +: 4], 10'h0}));

   // Target current: hold, load-adapted minimum or run
   always_comb
   begin
      if (reduceNow)
         targetScale = current_reg[CUR_HOLDLO +: 5];
      else if (ctrl_reg[CTRL_LOADADPT] && (loadMeasure >= {2'b00, load_reg[LOAD_THRLO +: 8]}))
         targetScale = load_reg[LOAD_MINLO +: 5];
      else
         targetScale = current_reg[CUR_RUNLO +: 5];
   end

   // Rises at once, falls one unit per decay period
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         currentScale <= 5'h1f;
         decayCnt_reg <= 8'h0;
      end
      else if (targetScale >= currentScale)
      begin
         currentScale <= targetScale;
         decayCnt_reg <= 8'h0;
      end
      else if (tickEn)
      begin
         if (decayCnt_reg >= current_reg[CUR_DECAYLO +: 8])
         begin
            currentScale <= currentScale - 5'h1;
            decayCnt_reg <= 8'h0;
         end
         else
            decayCnt_reg <= decayCnt_reg + 8'h1;
      end
   end

   // Bridge state and chopper choice
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         bridgeOff   <= 1'b0;
         brakeOn     <= 1'b0;
         cycleChopEn <= 1'b0;
      end
      else
      begin
         bridgeOff   <= reduceNow && (stillMode == STILL_FREE);
         brakeOn     <= reduceNow && (stillMode == STILL_BRAKE);
         cycleChopEn <= spiMode_reg ? ctrl_reg[CTRL_CYCCHOP] : sclkSync[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: zero wait, always OKAY
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         wrPend_reg <= 1'b0;
         wrAddr_reg <= 8'h00;
         hrdata     <= 32'h0;
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
      end
      else if (hready)
      begin
         wrPend_reg <= haddrSel && htrans[1] && hwrite && (hsize == 3'b010) && (haddr[31:8] == 24'h0);
         wrAddr_reg <= haddr[7:0];
         if (haddrSel && htrans[1] && !hwrite)
            hrdata <= (haddr[31:8] == 24'h0) ? readReg(haddr[7:0]) : 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial slave, mode 3: sample on rising clock, shift on falling
   assign csFall   = ~csSync[1] & csPrev;
   assign csRise   = csSync[1] & ~csPrev;
   assign sclkRise = sclkSync[1] & ~sclkPrev;
   assign sclkFall = ~sclkSync[1] & sclkPrev;

   always_ff @(posedge clk_sys)
   begin
      if (rst || !spiMode_reg)
      begin
         serState_reg <= SER_IDLE;
         rxShift_reg  <= 40'h0;
         txShift_reg  <= 40'h0;
         bitCnt_reg   <= 6'h0;
         spiRead_reg  <= 32'h0;
      end
      else
      begin
         case (serState_reg)
            SER_IDLE:
            begin
               if (csFall)
               begin
                  // Status byte then data of the previous read
                  txShift_reg  <= {5'h0, spiMode_reg, standstill, dirSync[1], spiRead_reg};
                  bitCnt_reg   <= 6'h0;
                  serState_reg <= SER_SHIFT;
               end
            end
            SER_SHIFT:
            begin
               if (csRise)
                  serState_reg <= (bitCnt_reg == FRAME_LEN) ? SER_DONE : SER_IDLE;
               else if (sclkRise)
               begin
                  rxShift_reg <= {rxShift_reg[38:0], mosiSync[1]};
                  if (bitCnt_reg != 6'h3f)
                     bitCnt_reg <= bitCnt_reg + 6'h1;
               end
               else if (sclkFall && bitCnt_reg != 6'h0)   // First bit already stands since select
                  txShift_reg <= {txShift_reg[38:0], 1'b0};
            end
            SER_DONE:
            begin
               // Reads answer in the next frame
               if (!rxShift_reg[39])
                  spiRead_reg <= readReg({rxShift_reg[37:32], 2'b00});
               serState_reg <= SER_IDLE;
            end
            default:
               serState_reg <= SER_IDLE;
         endcase
      end
   end
   assign spiWr   = (serState_reg == SER_DONE) && rxShift_reg[39];
   assign spiAddr = {rxShift_reg[37:32], 2'b00};
   assign spiData = rxShift_reg[31:0];

   // Data out driven only while selected in serial mode
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         miso_or_cfg_pin0_out <= 1'b0;
         miso_or_cfg_pin0_oe  <= 1'b0;
      end
      else
      begin
         miso_or_cfg_pin0_out <= txShift_reg[39];
         miso_or_cfg_pin0_oe  <= spiMode_reg && !csSync[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes; bus write wins over a coincident serial write
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         ctrl_reg    <= CTRL_RESET;
         current_reg <= CURRENT_RESET;
         direct_reg  <= 32'h0;
         load_reg    <= LOAD_RESET;
      end
      else if (wrPend_reg || spiWr)
      begin
         case (wrPend_reg ? wrAddr_reg : spiAddr)
            REG_CTRL:    ctrl_reg    <= wrPend_reg ? hwdata : spiData;
            REG_CURRENT: current_reg <= wrPend_reg ? hwdata : spiData;
            REG_DIRECT:  direct_reg  <= wrPend_reg ? hwdata : spiData;
            REG_LOAD:    load_reg    <= wrPend_reg ? hwdata : spiData;
            default:     ;   // Read-only or unmapped: ignored
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   chk_rise_step_up: assert property (@(posedge clk_sys) disable iff (rst)
      stepEdge && !dirSync[1] |=> msCnt_reg == 10'($past(msCnt_reg) + $past(stepIncr)))
      else $error("Step with direction low did not add");
   chk_step_down: assert property (@(posedge clk_sys) disable iff (rst)
      stepEdge && dirSync[1] |=> msCnt_reg == 10'($past(msCnt_reg) - $past(stepIncr)))
      else $error("Step with direction high did not subtract");
   chk_fall_ignored: assert property (@(posedge clk_sys) disable iff (rst)
      stepFall && !dualEdge |=> $stable(msCnt_reg))
      else $error("Falling edge counted in single edge mode");
   chk_full_incr: assert property (@(posedge clk_sys) disable iff (rst)
      resCode == RES_FULL |-> stepIncr == 10'd256)
      else $error("Fullstep increment wrong");
   chk_interp_smooth: assert property (@(posedge clk_sys) disable iff (rst)
      !stepEdge && !standstill |=> (10'(interp_reg - $past(interp_reg)) <= 10'd1) ||
                                   (10'($past(interp_reg) - interp_reg) <= 10'd1))
      else $error("Interpolator jumped");
   chk_table_follow: assert property (@(posedge clk_sys) disable iff (rst)
      !(spiMode_reg && ctrl_reg[CTRL_DIRECT]) |=> coilAMag == $past(sinMag) && coilBNeg == $past(cosNeg))
      else $error("Coil target does not follow table");
   chk_direct_coil: assert property (@(posedge clk_sys) disable iff (rst)
      spiMode_reg && ctrl_reg[CTRL_DIRECT] |=> coilBMag == $past(direct_reg[DIR_BMAGLO +: 8]))
      else $error("Direct mode value not applied");
   chk_standalone_quiet: assert property (@(posedge clk_sys) disable iff (rst)
      !spiMode_reg ##1 !spiMode_reg |-> !miso_or_cfg_pin0_oe)
      else $error("Data out driven in standalone mode");
   chk_frame_len: assert property (@(posedge clk_sys) disable iff (rst)
      serState_reg == SER_SHIFT && csRise && bitCnt_reg != FRAME_LEN |=> serState_reg == SER_IDLE)
      else $error("Short frame was executed");
   chk_freewheel: assert property (@(posedge clk_sys) disable iff (rst)
      reduceNow && stillMode == STILL_FREE |=> bridgeOff)
      else $error("Freewheel not applied at standstill");
   chk_chop_pin: assert property (@(posedge clk_sys) disable iff (rst)
      strapTaken_reg && !spiMode_reg |=> cycleChopEn == $past(sclkSync[1]))
      else $error("Chopper pin not honoured");
   chk_load_min: assert property (@(posedge clk_sys) disable iff (rst)
      !reduceNow && ctrl_reg[CTRL_LOADADPT] && loadMeasure >= {2'b00, load_reg[LOAD_THRLO +: 8]}
      |-> targetScale == load_reg[LOAD_MINLO +: 5])
      else $error("Load-adaptive minimum not used");
   cov_dual_edge: cover property (@(posedge clk_sys) disable iff (rst) stepFall && dualEdge);
   cov_frame: cover property (@(posedge clk_sys) disable iff (rst) spiWr);
   cov_reduce: cover property (@(posedge clk_sys) disable iff (rst) $rose(reduceNow));
endmodule // step_dir_front_end

/* sim/step_source.sv */
// Step and direction source standing in for the motion controller
`timescale 1ns/10ps
module step_source
(
   input  wire logic clk_sys,
   input  wire logic fire,    // One step toggle request
   input  wire logic dirReq,  // Direction for that toggle
   output logic      stepPin,
   output logic      dirPin
);
   logic [3:0] phase = 4'h0;  // Pulse sequencer, 16 clk per toggle
   initial stepPin = 1'b0;
   initial dirPin = 1'b0;
   // Dir settles 4 clk ahead of the edge so the sampler sees it
   always @(posedge clk_sys)
   begin
      if (phase == 4'h0)
      begin
         if (fire)
         begin
            dirPin <= dirReq;
            phase  <= 4'h1;
         end
      end
      else
      begin
         phase <= phase + 4'h1;
         if (phase == 4'h4)
            stepPin <= ~stepPin;
      end
   end
endmodule // step_source

/* sim/step_dir_microstep_front_end_bench.sv */
// Self-checking bench for the step/direction front end
`timescale 1ns/10ps
module step_dir_microstep_front_end_bench;
   import stepdir_pkg::*;
   logic        clk_sys = 1'b0, rst = 1'b1, haddrSel = 1'b0, hwrite = 1'b0, fire = 1'b0;
   logic        dirReq = 1'b0, stepLvl = 1'b0, dedge = 1'b0, hreadyout, stepPin, dirPin;
   logic        coilANeg, coilBNeg, d, strap = 1'b1, cs = 1'b1, sclk = 1'b1;
   logic        miso, misoOe, chop, bridgeOff, hresp;
   logic [1:0]  cfg = 2'b00;
   logic [39:0] rx = '0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, q, seed = 32'hd915388f;
   logic [1:0]  htrans = 2'b00;
   logic [2:0]  hsize = 3'b000;
   logic [3:0]  res = 4'h0;
   logic [4:0]  scale;
   logic [7:0]  coilAMag, coilBMag;
   logic [9:0]  loadMeasure = '0, cnt = '0;
   int          mismatches = 0, cmp_count = 0, cyc = 0;
   always #5 clk_sys = ~clk_sys;
   step_dir_front_end #(.STILL_TICKS(5), .FAST_STILL_TICKS(2)) i_dut
   (.clk_sys(clk_sys), .rst(rst), .haddrSel(haddrSel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .stepPin(stepPin), .dirPin(dirPin), .spiModeStrap(strap),
    .select_or_cfg_pin3(cs), .sclk_or_cfg_pin2(sclk), .mosi_or_cfg_pin1(cfg[1]),
    .miso_or_cfg_pin0_in(cfg[0]), .miso_or_cfg_pin0_out(miso), .miso_or_cfg_pin0_oe(misoOe),
    .loadMeasure(loadMeasure), .coilAMag(coilAMag), .coilANeg(coilANeg), .coilBMag(coilBMag),
    .coilBNeg(coilBNeg), .currentScale(scale), .cycleChopEn(chop), .bridgeOff(bridgeOff), .brakeOn());
   step_source i_src (.clk_sys(clk_sys), .fire(fire), .dirReq(dirReq), .stepPin(stepPin), .dirPin(dirPin));
   ////////////////////////////////////////////////////////////////////////////////
   // Repeatable pseudo-random source
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Counter increment for a resolution code
   function automatic logic [9:0] stepInc(input logic [3:0] c);
      return 10'h001 << c;
   endfunction
   // One AHB-Lite single word transfer, waits on hready each phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      haddr <= {24'h0, a};
      hwrite <= w;
      hsize <= 3'b010;
      htrans <= 2'b10;
      haddrSel <= 1'b1;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      htrans <= 2'b00;
      haddrSel <= 1'b0;
      hwdata <= wd;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      q = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One serial frame, mode 3, sclk half period 4 clk; out bit taken late in the high half
   task automatic frame(input logic [39:0] w);
      cs <= 1'b0;
      repeat (4) @(posedge clk_sys);
      for (int b = 39; b >= 0; b--)
      begin
         sclk <= 1'b0;
         cfg[1] <= w[b];
         repeat (4) @(posedge clk_sys);
         sclk <= 1'b1;
         repeat (4) @(posedge clk_sys);
         rx = {rx[38:0], miso};
      end
      chk({31'h0, misoOe}, 32'h1);
      cs <= 1'b1;
      repeat (6) @(posedge clk_sys);
   endtask
   // Toggle the step line and track what the counter should become
   task automatic toggle();
      dirReq <= d;
      fire <= 1'b1;
      @(posedge clk_sys);
      fire <= 1'b0;
      repeat (16) @(posedge clk_sys);
      stepLvl = ~stepLvl;
      if (dedge || stepLvl)
         cnt = d ? cnt - stepInc(res) : cnt + stepInc(res);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Hang guard, about four times the expected run
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         mismatches++;
         conclude();
      end
   end
   initial
   begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      chk({27'h0, scale}, 32'h1f);
      bus(1'b0, REG_CURRENT, 32'h0);
      chk(q, CURRENT_RESET);
      bus(1'b0, 8'h3c, 32'h0);
      chk(q, 32'h0);
      $display("reset test done");
      // Serial write, bus readback, then a read request answered in the next frame
      frame({2'b10, 6'd1, 32'h0100_0a1c});
      bus(1'b0, REG_CURRENT, 32'h0);
      chk(q, 32'h0100_0a1c);
      frame({2'b00, 6'd1, 32'h0});
      frame({2'b00, 6'd0, 32'h0});
      chk(rx[31:0], 32'h0100_0a1c);
      chk({24'h0, rx[39:32]}, 32'h06);
      $display("serial test done");
      // First nine pass every resolution code, then random modes
      for (int i = 0; i < 25; i++)
      begin
         seed = lfsr(seed);
         loadMeasure <= seed[25:16];
         res = (i < 9) ? i[3:0] : 4'(seed[3:0] % 9);
         dedge = (i < 9) ? i[0] : seed[4];
         d = (i < 9) ? i[1] : seed[5];
         bus(1'b1, REG_CTRL, {20'h0, res, 7'h0, dedge});
         repeat (1 + seed[7:6]) toggle();
         bus(1'b0, REG_STATUS, 32'h0);
         chk(q & 32'h3ff, {22'h0, cnt});
         chk(q & 32'h50000, 32'h40000);
      end
      $display("step test done");
      // Delay field is zero, so the scale decays to the hold value
      repeat (5000) @(posedge clk_sys);
      bus(1'b0, REG_STATUS, 32'h0);
      chk(q & 32'h10000, 32'h10000);
      chk({27'h0, scale}, 32'h0a);
      bus(1'b1, REG_DIRECT, 32'h0137_01a5);
      bus(1'b1, REG_CTRL, 32'h22);
      repeat (8) @(posedge clk_sys);
      chk({23'h0, coilANeg, coilAMag}, 32'h1a5);
      chk({23'h0, coilBNeg, coilBMag}, 32'h137);
      chk({31'h0, bridgeOff}, 32'h1);
      $display("direct test done");
      // Mid-run reset into standalone: pins pick dual edge, 16 microsteps, chopper
      strap <= 1'b0;
      cfg <= 2'b01;
      rst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      cnt = '0;
      res = 4'h4;
      dedge = 1'b1;
      d = 1'b0;
      repeat (2) toggle();
      bus(1'b0, REG_STATUS, 32'h0);
      chk(q & 32'h403ff, {22'h0, cnt});
      chk({31'h0, chop}, 32'h1);
      $display("standalone test done");
      conclude();
   end
endmodule // step_dir_microstep_front_end_bench
